// *** hdl/dsc_pkg.sv ***
// Shared constants for the two-wire DAC command front end.
package dsc_pkg;
	localparam int         ADDR_W        = 7;
	localparam int         STRAP_W       = 3;
	localparam int         CODE_W        = 10;
	localparam logic [3:0] OWN_ADDR_HI   = 4'h4;
	localparam logic [6:0] SYNC_ADDR     = 7'h7e;
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	localparam int         CMD_SY_POS    = 0;
	localparam int         CMD_PD_POS    = 1;
	localparam int         CMD_REF_POS   = 2;
	localparam logic [1:0] IDX_ADDR      = 2'h0;
	localparam logic [1:0] IDX_CMD       = 2'h1;
	localparam logic [1:0] IDX_LSB       = 2'h2;
	localparam logic [1:0] IDX_MSB       = 2'h3;
	localparam logic [9:0] CODE_RST      = 10'h000;
	localparam logic       BIT_RST       = 1'b0;
	localparam real        LINK_PERIOD_NS = 160.0;
	localparam real        SYS_PERIOD_NS  = 10.0;
	localparam int         LINK_CYCLES   = int'(LINK_PERIOD_NS / SYS_PERIOD_NS);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_SKIP
	} dsc_state_e;
endpackage : dsc_pkg

// *** hdl/dsc_sync2.sv ***
// Two-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/10ps
module dsc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
	} dsc_sync_s;

	dsc_sync_s s_q, s_d;

	if (W < 1) begin : g_bad_width
		$error("dsc_sync2 needs W of at least 1.");
	end

	// The first stage feeds only the second stage.
	always_comb begin
		s_d.ff1 = async_i;
		s_d.ff2 = s_q.ff1;
	end

	// Registers both stages; reset loads the idle high level so no false edge follows it.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_o = s_q.ff2;
endmodule : dsc_sync2

// *** hdl/dsc_line_mon.sv ***
// Bus line monitor: clock edges and start and stop conditions.
`timescale 1ns/10ps
module dsc_line_mon (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_rise_o,
	output logic      scl_fall_o,
	output logic      start_o,
	output logic      stop_o
);
	typedef struct packed {
		logic scl;
		logic sda;
	} dsc_mon_s;

	dsc_mon_s s_q, s_d;

	// Idle bus reads high on both lines.
	always_comb begin
		s_d.scl = scl_i;
		s_d.sda = sda_i;
	end

	// Keeps the previous sample of both lines.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	// Data changes while the clock stays high mark start and stop.
	assign scl_rise_o = scl_i & ~s_q.scl;
	assign scl_fall_o = ~scl_i & s_q.scl;
	assign start_o    = scl_i & s_q.scl & s_q.sda & ~sda_i;
	assign stop_o     = scl_i & s_q.scl & ~s_q.sda & sda_i;
endmodule : dsc_line_mon

// *** hdl/dsc_core.sv ***
// Receive-only two-wire command front end of a 10-bit DAC.
//
// Contract
// R1 - Address plus command byte alone is accepted as a command-only update.
// R2 - A cut-short word write falls back to a command-only transfer.
// R3 - Start or stop after command acknowledge keeps command, drops both data bytes.
// R4 - Start or stop before command acknowledge drops the partial command byte.
// R5 - Device also answers a shared sync address besides its own.
// R6 - Sync address is 1111110, sent as a quick command.
// R7 - The bit after the sync address is the sync-or-clear bit.
// R8 - Sync bit 1 with sync select set copies inputs to outputs on ack rise.
// R9 - Sync bit 0 always clears every latch.
// R10 - That clear happens on the rising clock edge of the acknowledge.
// R11 - Word write latches command, low, high bytes; stop updates outputs.
// R12 - Command bit 0 sync, bit 1 power-down at stop, bit 2 reference.
// R13 - With sync select set, stop does not update the output latches.
// R14 - Code is low byte plus bits 1..0 of the high byte.
// R15 - The sync address is acknowledged by pulling data low.
// R16 - Reset clears command bits, input registers and output latches.
`timescale 1ns/10ps
module dsc_core
	import dsc_pkg::*;
(
	input  wire logic                         clk_sys_i,
	input  wire logic                         rst_i,
	input  wire logic                         scl_i,
	input  wire logic                         sda_i,
	input  wire logic [dsc_pkg::STRAP_W-1:0]  addr_strap_i,
	output logic                              sda_o,
	output logic                              sda_oe_o,
	output logic      [dsc_pkg::CODE_W-1:0]   dac_code_o,
	output logic                              power_down_select_o,
	output logic                              internal_ref_select_o,
	output logic                              sync_update_select_o,
	output logic                              latch_update_o,
	output logic                              latch_clear_o
);
	import dsc_pkg::*;

	typedef struct packed {
		dsc_state_e        st;
		logic [1:0]        idx;
		logic [3:0]        bitcnt;
		logic [7:0]        shreg;
		logic              is_sync;
		logic              cmd_sy;
		logic              cmd_pd;
		logic              cmd_ref;
		logic              pend;
		logic [7:0]        lsb_tmp;
		logic [CODE_W-1:0] in_code;
		logic [CODE_W-1:0] out_code;
		logic              pd;
		logic              iref;
		logic              sda_oe;
		logic              sda;
		logic              upd;
		logic              clr;
	} dsc_core_s;

	dsc_core_s s_q, s_d;

	logic [STRAP_W+1:0] pins_sync;
	logic               scl_s;
	logic               sda_s;
	logic [STRAP_W-1:0] strap_s;
	logic               scl_rise;
	logic               scl_fall;
	logic               start_c;
	logic               stop_c;
	logic [ADDR_W-1:0]  own_addr;

	// The receiver assumes a seven-bit address and a ten-bit code.
	if (ADDR_W != 4 + STRAP_W || CODE_W != 10) begin : g_bad_widths
		$error("dsc_core needs a seven-bit address and a ten-bit code.");
	end

	// Every pin passes two flops before any logic reads it.
	dsc_sync2 #(
		.W (STRAP_W + 2)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.async_i   ({scl_i, sda_i, addr_strap_i}),
		.sync_o    (pins_sync)
	);

	assign scl_s    = pins_sync[STRAP_W+1];
	assign sda_s    = pins_sync[STRAP_W];
	assign strap_s  = pins_sync[STRAP_W-1:0];
	assign own_addr = {OWN_ADDR_HI, strap_s};

	// Edge and condition detection on the synchronised lines.
	dsc_line_mon u_mon (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.scl_i      (scl_s),
		.sda_i      (sda_s),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (start_c),
		.stop_o     (stop_c)
	);

	// Next-state logic for the whole receiver.
	always_comb begin
		s_d     = s_q;
		s_d.upd = 1'b0;
		s_d.clr = 1'b0;
		s_d.sda = 1'b0;
		if (start_c) begin
			// A new frame drops any partial byte and pending data byte. [R3] [R4]
			s_d.st     = ST_RX;
			s_d.idx    = IDX_ADDR;
			s_d.bitcnt = 4'h0;
			s_d.sda_oe = 1'b0;
		end else if (stop_c) begin
			s_d.st     = ST_IDLE;
			s_d.sda_oe = 1'b0;
			if (s_q.pend) begin
				// Accepted command applies at stop, with or without data. [R1] [R2] [R12]
				s_d.pend = 1'b0;
				s_d.pd   = s_q.cmd_pd;
				s_d.iref = s_q.cmd_ref;
				if (!s_q.cmd_sy) begin
					s_d.out_code = s_q.in_code; // [R11] [R13]
					s_d.upd      = 1'b1;
				end
			end
		end else begin
			case (s_q.st)
				ST_RX: begin
					if (scl_rise) begin
						s_d.shreg  = {s_q.shreg[6:0], sda_s};
						s_d.bitcnt = s_q.bitcnt + 4'h1;
					end else if (scl_fall && s_q.bitcnt == BYTE_BITS) begin
						s_d.bitcnt = 4'h0;
						if (s_q.idx != IDX_ADDR) begin
							s_d.st     = ST_ACK;
							s_d.sda_oe = 1'b1;
						end else if (s_q.shreg[7:1] == SYNC_ADDR) begin
							// Shared address takes any direction bit. [R5] [R6] [R15]
							s_d.st      = ST_ACK;
							s_d.sda_oe  = 1'b1;
							s_d.is_sync = 1'b1;
						end else if (s_q.shreg[7:1] == own_addr && !s_q.shreg[0]) begin
							s_d.st      = ST_ACK;
							s_d.sda_oe  = 1'b1;
							s_d.is_sync = 1'b0;
						end else begin
							s_d.st = ST_SKIP;
						end
					end
				end
				ST_ACK: begin
					if (scl_rise) begin
						case (s_q.idx)
							IDX_ADDR: begin
								// Bit after sync address is sync-or-clear. [R7]
								if (s_q.is_sync && !s_q.shreg[0]) begin
									// Clear every latch on the acknowledge rise. [R9] [R10]
									s_d.cmd_sy   = BIT_RST;
									s_d.cmd_pd   = BIT_RST;
									s_d.cmd_ref  = BIT_RST;
									s_d.pend     = 1'b0;
									s_d.lsb_tmp  = 8'h00;
									s_d.in_code  = CODE_RST;
									s_d.out_code = CODE_RST;
									s_d.pd       = BIT_RST;
									s_d.iref     = BIT_RST;
									s_d.clr      = 1'b1;
								end else if (s_q.is_sync && s_q.cmd_sy) begin
									s_d.out_code = s_q.in_code; // [R8]
									s_d.upd      = 1'b1;
								end
							end
							IDX_CMD: begin
								// Command byte kept from its acknowledge on. [R3] [R12]
								s_d.cmd_sy  = s_q.shreg[CMD_SY_POS];
								s_d.cmd_pd  = s_q.shreg[CMD_PD_POS];
								s_d.cmd_ref = s_q.shreg[CMD_REF_POS];
								s_d.pend    = 1'b1;
							end
							IDX_LSB: begin
								s_d.lsb_tmp = s_q.shreg;
							end
							default: begin
								// Data enters only on the last acknowledge. [R14] [R3]
								s_d.in_code = {s_q.shreg[1:0], s_q.lsb_tmp};
							end
						endcase
					end else if (scl_fall) begin
						s_d.sda_oe = 1'b0;
						if ((s_q.idx == IDX_ADDR && s_q.is_sync) || s_q.idx == IDX_MSB) begin
							s_d.st = ST_SKIP;
						end else begin
							s_d.idx = s_q.idx + 2'h1;
							s_d.st  = ST_RX;
						end
					end
				end
				default: begin
					s_d.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// State register; reset clears commands, inputs and outputs. [R16]
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_q          <= '0;
			s_q.st       <= ST_IDLE;
			s_q.in_code  <= CODE_RST;
			s_q.out_code <= CODE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register.
	assign sda_o                 = s_q.sda;
	assign sda_oe_o              = s_q.sda_oe;
	assign dac_code_o            = s_q.out_code;
	assign power_down_select_o   = s_q.pd;
	assign internal_ref_select_o = s_q.iref;
	assign sync_update_select_o  = s_q.cmd_sy;
	assign latch_update_o        = s_q.upd;
	assign latch_clear_o         = s_q.clr;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// Checks on the receiver behaviour.
	chk_start_abort: assert property (start_c |=> s_q.st == ST_RX && s_q.idx == IDX_ADDR) // [R4]
		else $error("Start did not restart address reception.");
	chk_stop_release: assert property (stop_c |=> !sda_oe_o && s_q.st == ST_IDLE) // [R3]
		else $error("Stop did not release the bus.");
	chk_cmd_latch: assert property (s_q.st == ST_ACK && s_q.idx == IDX_CMD // [R1]
		&& scl_rise |=> s_q.pend && sync_update_select_o == $past(s_q.shreg[CMD_SY_POS]))
		else $error("Command byte not taken on its acknowledge.");
	chk_sync_clear: assert property (s_q.st == ST_ACK && s_q.idx == IDX_ADDR // [R9] [R10]
		&& s_q.is_sync && !s_q.shreg[0] && scl_rise
		|=> dac_code_o == CODE_RST && latch_clear_o && !power_down_select_o)
		else $error("Sync clear did not clear the latches.");
	chk_sync_update: assert property (s_q.st == ST_ACK && s_q.idx == IDX_ADDR // [R8]
		&& s_q.is_sync && s_q.shreg[0] && s_q.cmd_sy && scl_rise
		|=> dac_code_o == $past(s_q.in_code) && latch_update_o)
		else $error("Sync update did not copy the input code.");
	chk_no_stop_upd: assert property (stop_c && s_q.cmd_sy |=> $stable(dac_code_o)) // [R13]
		else $error("Stop changed outputs with sync select set.");
	chk_code_build: assert property (s_q.st == ST_ACK && s_q.idx == IDX_MSB // [R14]
		&& scl_rise |=> s_q.in_code == {$past(s_q.shreg[1:0]), $past(s_q.lsb_tmp)})
		else $error("Input code assembled wrongly.");
	chk_stop_upd: assert property (stop_c && s_q.pend && !s_q.cmd_sy // [R11] [R2]
		|=> dac_code_o == $past(s_q.in_code) && latch_update_o ##1 !latch_update_o)
		else $error("Stop did not update the output code.");
	chk_sync_ack: assert property (s_q.st == ST_RX && s_q.idx == IDX_ADDR // [R15] [R5]
		&& scl_fall && s_q.bitcnt == BYTE_BITS && s_q.shreg[7:1] == SYNC_ADDR |=> sda_oe_o)
		else $error("Sync address not acknowledged.");

	// The data line is only pulled during an acknowledge clock.
	chk_oe_in_ack: assert property (sda_oe_o |-> s_q.st == ST_ACK) // [R15]
		else $error("Data line pulled outside an acknowledge.");
	// A read request to the own address is left unanswered.
	chk_read_refused: assert property (s_q.st == ST_RX && s_q.idx == IDX_ADDR // [R11]
		&& scl_fall && s_q.bitcnt == BYTE_BITS && s_q.shreg[7:1] == own_addr && s_q.shreg[0]
		|=> !sda_oe_o && s_q.st == ST_SKIP)
		else $error("Read request to the own address was acknowledged.");
	// A sync update is ignored while sync select is clear.
	chk_sync_ignored: assert property (s_q.st == ST_ACK && s_q.idx == IDX_ADDR // [R8]
		&& s_q.is_sync && s_q.shreg[0] && !s_q.cmd_sy && scl_rise
		|=> $stable(dac_code_o) && !latch_update_o)
		else $error("Sync update acted with sync select clear.");
	// A cut command byte leaves the stored command untouched.
	chk_partial_cmd: assert property ((start_c || stop_c) && s_q.st == ST_RX // [R4]
		&& s_q.idx == IDX_CMD |=> $stable(sync_update_select_o))
		else $error("Cut command byte changed the stored command.");
	// Neither start nor stop ever moves data into the input code.
	chk_cut_data: assert property (start_c || stop_c |=> $stable(s_q.in_code)) // [R3]
		else $error("Start or stop changed the input code.");
	// Power-down and reference change only at stop or on a sync clear.
	chk_pd_at_stop: assert property (!stop_c // [R12]
		|=> $stable(power_down_select_o) || latch_clear_o)
		else $error("Power-down changed away from a stop.");
	chk_ref_at_stop: assert property (!stop_c // [R12]
		|=> $stable(internal_ref_select_o) || latch_clear_o)
		else $error("Reference select changed away from a stop.");
	// No byte after the high data byte is acknowledged.
	chk_no_byte_five: assert property (s_q.st == ST_ACK && s_q.idx == IDX_MSB // [R11]
		&& scl_fall |=> s_q.st == ST_SKIP)
		else $error("Receiver did not stop after the high data byte.");
	// Update and clear strobes last a single cycle.
	chk_upd_pulse: assert property (latch_update_o |=> !latch_update_o) // [R11]
		else $error("Update strobe lasted more than one cycle.");
	chk_clr_pulse: assert property (latch_clear_o |=> !latch_clear_o) // [R10]
		else $error("Clear strobe lasted more than one cycle.");

	// Main scenarios that the bench should reach.
	cov_word_write: cover property (s_q.st == ST_ACK && s_q.idx == IDX_MSB && scl_fall);
	cov_sync_update: cover property (latch_update_o && s_q.cmd_sy);
	cov_sync_clear: cover property (latch_clear_o);
	cov_cut_short: cover property (stop_c && s_q.pend && s_q.idx == IDX_LSB);
	cov_restart: cover property (start_c && s_q.pend && s_q.st != ST_IDLE);
endmodule : dsc_core

// *** tb/dsc_bus_master.sv ***
// Behavioural two-wire bus master that drives clock and data by release or pull low.
`timescale 1ns/10ps
module dsc_bus_master (
	input  wire logic clk_sys_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	// Both lines start released, so the pull-ups hold them high between frames.
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : hold
	// Data falls while the clock is high; this also serves as a repeated start.
	task automatic start();
		sda_o = 1'b1;
		hold(4);
		scl_o = 1'b1;
		hold(4);
		sda_o = 1'b0;
		hold(4);
		scl_o = 1'b0;
		hold(4);
	endtask : start
	// Data rises while the clock is high; the clock then stands still.
	task automatic stop();
		sda_o = 1'b0;
		hold(4);
		scl_o = 1'b1;
		hold(4);
		sda_o = 1'b1;
		hold(8);
	endtask : stop
	// One bit cell of 16 cycles, data changed only while the clock is low.
	task automatic put_bit(input logic b);
		sda_o = b;
		hold(4);
		scl_o = 1'b1;
		hold(8);
		scl_o = 1'b0;
		hold(4);
	endtask : put_bit
	// Eight bits first to last, then the line is released for the acknowledge.
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) put_bit(b[i]);
		sda_o = 1'b1;
		hold(4);
		scl_o = 1'b1;
		hold(4);
		ack = ~sda_i;
		hold(4);
		scl_o = 1'b0;
		hold(4);
	endtask : send_byte
endmodule : dsc_bus_master

// *** tb/tb_top.sv ***
// Self-checking bench for the two-wire DAC command front end.
`timescale 1ns/10ps
module tb_top;
	import dsc_pkg::*;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] lsb;
		logic [7:0] msb;
		logic [9:0] code;
		logic       pd;
		logic       rf;
	} dsc_row_s;
	localparam logic [7:0] OWN_W = {OWN_ADDR_HI, 3'h5, 1'b0};
	localparam int         LIMIT = 20000;
	logic       clk_sys_i, rst_i, m_scl, m_sda, sda_o, sda_oe_o, pd_o, ref_o, sy_o, ack;
	logic       upd_o, clr_o;
	logic [9:0] code_o;
	int         fails = 0, checks = 0, cyc = 0, upd_n = 0, clr_n = 0, base;
	// The open-drain data wire is low when either party pulls it.
	wire logic  sda_w = m_sda & ~(sda_oe_o & ~sda_o);
	dsc_row_s   rows [3] = '{{8'h00, 8'hff, 8'h03, 10'h3ff, 2'b00},
		{8'hfe, 8'h5a, 8'hfd, 10'h15a, 2'b11}, {8'h04, 8'h00, 8'h02, 10'h200, 2'b01}};
	dsc_core u_dsc_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(m_scl), .sda_i(sda_w),
		.addr_strap_i(3'h5), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .dac_code_o(code_o),
		.power_down_select_o(pd_o), .internal_ref_select_o(ref_o),
		.sync_update_select_o(sy_o), .latch_update_o(upd_o), .latch_clear_o(clr_o));
	dsc_bus_master u_dsc_bus_master (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(m_scl),
		.sda_o(m_sda));
	// The clock runs at 100 MHz.
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Pulses are counted, and a hung run is cut short.
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (upd_o === 1'b1) upd_n <= upd_n + 1;
		if (clr_o === 1'b1) clr_n <= clr_n + 1;
		if (cyc == LIMIT) begin
			fails++;
			end_of_test();
		end
	end
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic outs(input logic [9:0] c, input logic p, input logic r, input logic s);
		check(code_o, c);
		check({7'h0, pd_o, ref_o, sy_o}, {7'h0, p, r, s});
	endtask : outs
	// A start followed by one address byte whose acknowledge is compared.
	task automatic probe(input logic [7:0] a, input logic e);
		u_dsc_bus_master.start();
		u_dsc_bus_master.send_byte(a, ack);
		check(10'(ack), 10'(e));
	endtask : probe
	task automatic wr(input logic [7:0] c, input logic [7:0] l, input logic [7:0] m,
		input int n);
		logic [7:0] b [3];
		b = '{c, l, m};
		probe(OWN_W, 1'b1);
		for (int i = 0; i < n; i++) begin
			u_dsc_bus_master.send_byte(b[i], ack);
			check(10'(ack), 10'h1);
		end
		u_dsc_bus_master.stop();
	endtask : wr
	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	// Main sequence: reset, table of word writes, then the awkward cases.
	initial begin
		rst_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		rst_i = 1'b0;
		outs(10'h0, 1'b0, 1'b0, 1'b0);
		u_dsc_bus_master.hold(4);
		foreach (rows[i]) begin
			wr(rows[i].cmd, rows[i].lsb, rows[i].msb, 3);
			outs(rows[i].code, rows[i].pd, rows[i].rf, 1'b0);
			check(10'(upd_n), 10'(i + 1));
		end
		probe(OWN_W ^ 8'h02, 1'b0);
		u_dsc_bus_master.stop();
		probe(8'hfe, 1'b0);
		u_dsc_bus_master.stop();
		probe(OWN_W | 8'h01, 1'b0);
		u_dsc_bus_master.stop();
		wr(8'h02, 8'h00, 8'h00, 1);
		outs(10'h200, 1'b1, 1'b0, 1'b0);
		wr(8'h04, 8'h11, 8'h01, 2);
		outs(10'h200, 1'b0, 1'b1, 1'b0);
		probe(OWN_W, 1'b1);
		for (int i = 0; i < 4; i++) u_dsc_bus_master.put_bit(1'b1);
		u_dsc_bus_master.stop();
		outs(10'h200, 1'b0, 1'b1, 1'b0);
		wr(8'h01, 8'h34, 8'h02, 3);
		outs(10'h200, 1'b0, 1'b0, 1'b1);
		base = upd_n;
		probe({SYNC_ADDR, 1'b1}, 1'b1);
		outs(10'h234, 1'b0, 1'b0, 1'b1);
		check(10'(upd_n), 10'(base + 1));
		u_dsc_bus_master.stop();
		wr(8'h00, 8'h55, 8'h00, 3);
		outs(10'h055, 1'b0, 1'b0, 1'b0);
		base = upd_n;
		probe({SYNC_ADDR, 1'b1}, 1'b1);
		u_dsc_bus_master.stop();
		outs(10'h055, 1'b0, 1'b0, 1'b0);
		check(10'(upd_n), 10'(base));
		wr(8'h07, 8'hff, 8'h03, 3);
		outs(10'h055, 1'b1, 1'b1, 1'b1);
		base = clr_n;
		probe({SYNC_ADDR, 1'b0}, 1'b1);
		outs(10'h000, 1'b0, 1'b0, 1'b0);
		check(10'(clr_n), 10'(base + 1));
		u_dsc_bus_master.stop();
		wr(8'h00, 8'h00, 8'h00, 1);
		outs(10'h000, 1'b0, 1'b0, 1'b0);
		wr(8'h00, 8'h99, 8'h01, 3);
		outs(10'h199, 1'b0, 1'b0, 1'b0);
		probe(OWN_W, 1'b1);
		u_dsc_bus_master.send_byte(8'h02, ack);
		check(10'(ack), 10'h1);
		probe(OWN_W, 1'b1);
		u_dsc_bus_master.stop();
		outs(10'h199, 1'b1, 1'b0, 1'b0);
		rst_i = 1'b1;
		u_dsc_bus_master.hold(8);
		rst_i = 1'b0;
		outs(10'h0, 1'b0, 1'b0, 1'b0);
		u_dsc_bus_master.hold(4);
		wr(8'h00, 8'h00, 8'h00, 1);
		outs(10'h0, 1'b0, 1'b0, 1'b0);
		end_of_test();
	end
endmodule : tb_top
